//--- logic/cpi_pin_if.sv
/*
  Pin-side logic of a 32-bit processor core: memory cycle flags, write
  drive, coprocessor handshake, interrupt inputs, mode/status and TAP pins.
  Assumes all inputs but the interrupt pins, the test clock included, are synchronous to i_clk.
*/
// Overview of operation
// - TAP instruction output updates only on test clock fall in update-IR.
// - Interrupt inputs used directly when sync select high, else synchronised.
// - Lock high during locked access, only for swap instruction.
// - Size codes byte 00, half 01, word 10; never 11.
// - Access size stable for the whole memory cycle.
// - Everything runs from the single main clock.
// - Coprocessor instruction output low, then wait for absent and busy.
// - Absent high at first edge aborts to undefined instruction trap.
// - Absent low: wait while busy high, then complete handshake.
// - Data bus driven in writes only while write drive enable low; the enable is registered here, so the bus follows it one cycle late.
// - Write cycle flag low for the whole write cycle.
// - Comms transfer flag low during debug channel transfer into core.
// - Skipped instruction flag high when executed instruction is skipped.
// - Fast interrupt taken when request low and its enable active.
// - Normal interrupt like fast but lower priority, own enable.
// - Float select low while TAP instruction is the float instruction.
// - Mode outputs are the inverse of the five mode bits.
// - Memory request low one cycle before each access cycle.
// - Fetch flag low for instruction fetches, high for data.
// - Stretch request low extends the current access.
module cpi_pin_if #(
  parameter int DATA_WIDTH = 32
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Core side: memory access requests
  input wire logic i_acc_valid,
  input wire cpi_pkg::cpi_access_t i_acc,
  input wire logic [DATA_WIDTH-1:0] i_wdata,
  output logic o_acc_ready,
  output logic o_acc_done,
  // Memory side pins
  input wire logic i_stretch_request_n,
  input wire logic i_write_drive_enable_n,
  output logic o_mem_request_n,
  output logic [1:0] o_access_size,
  output logic o_fetch_flag_n,
  output logic o_lock,
  output logic o_write_cycle_flag_n,
  output logic [DATA_WIDTH-1:0] o_wdata,
  output logic o_wdata_oe,
  // Core side: coprocessor
  input wire logic i_cp_req,
  input wire logic i_cp_comms_xfer,
  output logic o_cp_done,
  output logic o_cp_undef,
  // Coprocessor pins
  input wire logic i_coproc_absent,
  input wire logic i_coproc_busy,
  output logic o_coproc_instr_n,
  output logic o_comms_transfer_flag_n,
  // Interrupts
  input wire cpi_pkg::cpi_int_pins_t i_int_pins,
  input wire logic i_interrupt_sync_select,
  input wire logic i_fast_int_enable,
  input wire logic i_normal_int_enable,
  output logic o_fast_int_take,
  output logic o_normal_int_take,
  // Status
  input wire logic [4:0] i_mode_bits,
  input wire logic i_instr_skipped,
  output logic [4:0] o_mode_bits_inv,
  output logic o_skipped_instr_flag,
  // TAP
  input wire logic i_tck,
  input wire logic i_tap_update_ir,
  input wire logic [3:0] i_tap_ir_next,
  output logic [3:0] o_tap_instruction_out,
  output logic o_float_select_n
);

  if (DATA_WIDTH < 8 || DATA_WIDTH % 8 != 0) begin : g_width_chk
    $error("cpi_pin_if: DATA_WIDTH must be a positive multiple of 8");
  end

  cpi_pkg::cpi_acc_state_t acc_state_q;
  cpi_pkg::cpi_access_t acc_q;
  logic [DATA_WIDTH-1:0] wdata_hold_q;
  logic mem_request_n_q;
  logic [1:0] access_size_q;
  logic fetch_flag_n_q;
  logic lock_q;
  logic write_cycle_flag_n_q;
  logic [DATA_WIDTH-1:0] wdata_q;
  logic wdata_oe_q;
  logic acc_ready_q;
  logic acc_done_q;
  logic [1:0] legal_size;
  logic access_ends;

  // Reserved code is folded onto word so the pins never show it
  assign legal_size = (i_acc.size == cpi_pkg::SIZE_BYTE) ? cpi_pkg::SIZE_BYTE :
                      (i_acc.size == cpi_pkg::SIZE_HALF) ? cpi_pkg::SIZE_HALF :
                      cpi_pkg::SIZE_WORD;
  assign access_ends = (acc_state_q == cpi_pkg::ACC_ACTIVE) && i_stretch_request_n;

  // Access sequencer
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      acc_state_q <= cpi_pkg::ACC_IDLE;
      acc_q <= '0;
      wdata_hold_q <= '0;
    end else begin
      case (acc_state_q)
        cpi_pkg::ACC_IDLE: begin
          if (i_acc_valid) begin
            acc_q <= '{size: legal_size, write: i_acc.write,
                       fetch: i_acc.fetch, swap: i_acc.swap};
            wdata_hold_q <= i_wdata;
            acc_state_q <= cpi_pkg::ACC_ANNOUNCE;
          end
        end
        cpi_pkg::ACC_ANNOUNCE: begin
          acc_state_q <= cpi_pkg::ACC_ACTIVE;
        end
        cpi_pkg::ACC_ACTIVE: begin
          if (i_stretch_request_n) begin
            acc_state_q <= cpi_pkg::ACC_IDLE;
          end
        end
        default: begin
          acc_state_q <= cpi_pkg::ACC_IDLE;
        end
      endcase
    end
  end

  // Handshake to the core
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      acc_ready_q <= 1'b1;
      acc_done_q <= 1'b0;
    end else begin
      acc_ready_q <= (acc_state_q == cpi_pkg::ACC_IDLE) ? !i_acc_valid : access_ends;
      acc_done_q <= access_ends;
    end
  end

  // One cycle ahead of the access
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mem_request_n_q <= 1'b1;
    end else begin
      mem_request_n_q <= !((acc_state_q == cpi_pkg::ACC_IDLE) && i_acc_valid);
    end
  end

  // Cycle flags change only at the cycle boundary, so they hold all cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      access_size_q <= cpi_pkg::SIZE_RESET;
      fetch_flag_n_q <= 1'b1;
      lock_q <= 1'b0;
      write_cycle_flag_n_q <= 1'b1;
    end else if (acc_state_q == cpi_pkg::ACC_ANNOUNCE) begin
      access_size_q <= acc_q.size;
      fetch_flag_n_q <= !acc_q.fetch;
      lock_q <= acc_q.swap;
      write_cycle_flag_n_q <= !acc_q.write;
    end else if (access_ends) begin
      fetch_flag_n_q <= 1'b1;
      lock_q <= 1'b0;
      write_cycle_flag_n_q <= 1'b1;
    end
  end

  // Enable sampled once per cycle; one cycle of lag behind the pin
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wdata_q <= '0;
      wdata_oe_q <= 1'b0;
    end else begin
      wdata_q <= wdata_hold_q;
      wdata_oe_q <= acc_q.write && !i_write_drive_enable_n &&
                    ((acc_state_q == cpi_pkg::ACC_ANNOUNCE) ||
                     ((acc_state_q == cpi_pkg::ACC_ACTIVE) && !i_stretch_request_n));
    end
  end

  // Coprocessor handshake
  cpi_pkg::cpi_cp_state_t cp_state_q;
  logic coproc_instr_n_q;
  logic cp_done_q;
  logic cp_undef_q;
  logic comms_flag_n_q;
  logic cp_ends;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cp_state_q <= cpi_pkg::CP_IDLE;
      coproc_instr_n_q <= 1'b1;
      cp_done_q <= 1'b0;
      cp_undef_q <= 1'b0;
    end else begin
      cp_done_q <= 1'b0;
      cp_undef_q <= 1'b0;
      case (cp_state_q)
        cpi_pkg::CP_IDLE: begin
          if (i_cp_req) begin
            coproc_instr_n_q <= 1'b0;
            cp_state_q <= cpi_pkg::CP_PROBE;
          end
        end
        cpi_pkg::CP_PROBE: begin
          if (i_coproc_absent) begin
            coproc_instr_n_q <= 1'b1;
            cp_undef_q <= 1'b1;
            cp_state_q <= cpi_pkg::CP_IDLE;
          end else if (!i_coproc_busy) begin
            coproc_instr_n_q <= 1'b1;
            cp_done_q <= 1'b1;
            cp_state_q <= cpi_pkg::CP_IDLE;
          end else begin
            cp_state_q <= cpi_pkg::CP_BUSY;
          end
        end
        cpi_pkg::CP_BUSY: begin
          if (!i_coproc_busy) begin
            coproc_instr_n_q <= 1'b1;
            cp_done_q <= 1'b1;
            cp_state_q <= cpi_pkg::CP_IDLE;
          end
        end
        default: begin
          cp_state_q <= cpi_pkg::CP_IDLE;
        end
      endcase
    end
  end

  // Comms flag opens and closes with the instruction pin, never after it
  assign cp_ends = (cp_state_q == cpi_pkg::CP_PROBE) ? (i_coproc_absent || !i_coproc_busy) :
                   ((cp_state_q == cpi_pkg::CP_BUSY) && !i_coproc_busy);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      comms_flag_n_q <= 1'b1;
    end else if (cp_state_q == cpi_pkg::CP_IDLE) begin
      comms_flag_n_q <= !(i_cp_req && i_cp_comms_xfer);
    end else if (cp_ends) begin
      comms_flag_n_q <= 1'b1;
    end
  end

  // Interrupt inputs
  cpi_pkg::cpi_int_pins_t int_synced;
  cpi_pkg::cpi_int_pins_t int_used;
  logic fast_take_q;
  logic normal_take_q;

  cpi_sync #(
    .WIDTH($bits(cpi_pkg::cpi_int_pins_t)),
    .RESET_VAL(2'h3)
  ) u_int_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_int_pins),
    .o_sync(int_synced)
  );

  // Bypass saves two cycles of latency when the source is already clocked
  assign int_used = i_interrupt_sync_select ? i_int_pins : int_synced;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fast_take_q <= 1'b0;
      normal_take_q <= 1'b0;
    end else begin
      fast_take_q <= !int_used.fast_n && i_fast_int_enable;
      normal_take_q <= !int_used.normal_n && i_normal_int_enable &&
                       !(!int_used.fast_n && i_fast_int_enable);
    end
  end

  // Status pins
  logic [4:0] mode_inv_q;
  logic skipped_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_inv_q <= cpi_pkg::MODE_INV_RESET;
      skipped_q <= 1'b0;
    end else begin
      mode_inv_q <= ~i_mode_bits;
      skipped_q <= i_instr_skipped;
    end
  end

  // TAP pins; test clock is sampled, so it must run well below i_clk
  logic tck_q;
  logic tck_fall;
  logic [3:0] tap_ir_q;
  logic float_n_q;

  assign tck_fall = tck_q && !i_tck;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tck_q <= 1'b0;
      tap_ir_q <= cpi_pkg::TAP_IR_RESET;
      float_n_q <= 1'b1;
    end else begin
      tck_q <= i_tck;
      if (tck_fall && i_tap_update_ir) begin
        tap_ir_q <= i_tap_ir_next;
        float_n_q <= (i_tap_ir_next != cpi_pkg::FLOAT_INSTRUCTION);
      end
    end
  end

  assign o_acc_ready = acc_ready_q;
  assign o_acc_done = acc_done_q;
  assign o_mem_request_n = mem_request_n_q;
  assign o_access_size = access_size_q;
  assign o_fetch_flag_n = fetch_flag_n_q;
  assign o_lock = lock_q;
  assign o_write_cycle_flag_n = write_cycle_flag_n_q;
  assign o_wdata = wdata_q;
  assign o_wdata_oe = wdata_oe_q;
  assign o_cp_done = cp_done_q;
  assign o_cp_undef = cp_undef_q;
  assign o_coproc_instr_n = coproc_instr_n_q;
  assign o_comms_transfer_flag_n = comms_flag_n_q;
  assign o_fast_int_take = fast_take_q;
  assign o_normal_int_take = normal_take_q;
  assign o_mode_bits_inv = mode_inv_q;
  assign o_skipped_instr_flag = skipped_q;
  assign o_tap_instruction_out = tap_ir_q;
  assign o_float_select_n = float_n_q;

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  size_never_reserved_a: assert property (o_access_size != 2'h3)
    else $error("access size shows reserved code");
  lock_only_swap_a: assert property (o_lock |->
    acc_q.swap && acc_state_q == cpi_pkg::ACC_ACTIVE)
    else $error("lock high outside swap");
  request_ahead_a: assert property (!o_mem_request_n |=>
    o_mem_request_n && acc_state_q == cpi_pkg::ACC_ACTIVE)
    else $error("access did not follow memory request");
  stretch_holds_size_a: assert property (acc_state_q == cpi_pkg::ACC_ACTIVE &&
    !i_stretch_request_n |=> acc_state_q == cpi_pkg::ACC_ACTIVE && $stable(o_access_size))
    else $error("stretched access not held");
  write_flag_cycle_a: assert property (acc_state_q == cpi_pkg::ACC_ACTIVE &&
    acc_q.write |-> !o_write_cycle_flag_n)
    else $error("write flag not low in write cycle");
  drive_needs_enable_a: assert property (o_wdata_oe |-> !o_write_cycle_flag_n &&
    $past(!i_write_drive_enable_n))
    else $error("data bus driven without enable");
  cp_abort_undef_a: assert property (cp_state_q == cpi_pkg::CP_PROBE && i_coproc_absent
    |=> o_cp_undef && o_coproc_instr_n && !o_cp_done)
    else $error("absent coprocessor not trapped");
  cp_busy_wait_a: assert property (cp_state_q != cpi_pkg::CP_IDLE && !i_coproc_absent &&
    i_coproc_busy |=> !o_cp_done && !o_coproc_instr_n)
    else $error("handshake completed while busy");
  fast_over_normal_a: assert property (o_normal_int_take |-> !o_fast_int_take)
    else $error("normal interrupt taken over fast");
  mode_inverse_a: assert property (!$past(i_sys_rst) |->
    o_mode_bits_inv == ~$past(i_mode_bits))
    else $error("mode outputs not inverted bits");
  tap_update_edge_a: assert property (!$past(i_sys_rst) &&
    o_tap_instruction_out != $past(o_tap_instruction_out) |-> $past(tck_fall && i_tap_update_ir))
    else $error("TAP instruction changed outside update");
  float_match_a: assert property (o_float_select_n ==
    (o_tap_instruction_out != cpi_pkg::FLOAT_INSTRUCTION))
    else $error("float select mismatch");

  swap_access_c: cover property (o_lock ##1 o_acc_done);
  stretched_write_c: cover property (!o_write_cycle_flag_n && !i_stretch_request_n [*2]);
  cp_undef_c: cover property (o_cp_undef);
  cp_busy_done_c: cover property (cp_state_q == cpi_pkg::CP_BUSY ##[1:8] o_cp_done);

endmodule

//--- logic/cpi_pkg.sv
/*
  Shared constants and types for the processor pin interface block.
  Assumes one clock domain and a synchronous, active-high reset.
*/
package cpi_pkg;

  // Transfer size codes on the access size pins; 2'h3 is never driven
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // Arbitrary default: the float_instruction encoding is set by the TAP design
  localparam logic [3:0] FLOAT_INSTRUCTION = 4'h7;

  // Reset values of the pin outputs
  localparam logic [3:0] TAP_IR_RESET = 4'hE;
  localparam logic [4:0] MODE_INV_RESET = 5'h1F;
  localparam logic [1:0] SIZE_RESET = 2'h0;

  // Stages of the interrupt synchroniser
  localparam int SYNC_STAGES = 2;

  // One memory access as the core asks for it
  typedef struct packed {
    logic [1:0] size;
    logic write;
    logic fetch;
    logic swap;
  } cpi_access_t;

  // Raw interrupt pins, both active low
  typedef struct packed {
    logic fast_n;
    logic normal_n;
  } cpi_int_pins_t;

  typedef enum logic [2:0] {
    ACC_IDLE = 3'h1,
    ACC_ANNOUNCE = 3'h2,
    ACC_ACTIVE = 3'h4
  } cpi_acc_state_t;

  typedef enum logic [2:0] {
    CP_IDLE = 3'h1,
    CP_PROBE = 3'h2,
    CP_BUSY = 3'h4
  } cpi_cp_state_t;

endpackage

//--- logic/cpi_sync.sv
/*
  Two-flop level synchroniser, parameterised width.
  Assumes the input may change at any time relative to i_clk.
*/
module cpi_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  if (WIDTH < 1) begin : g_width_chk
    $error("cpi_sync: WIDTH must be at least 1");
  end

  // First stage feeds the second stage only
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

//--- tb/cpi_far_side_model.sv
/*
  Far side of the pin block: memory controller wait stretching and a
  coprocessor answering the handshake. Assumes one clock, sync reset.
*/
module cpi_far_side_model (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_stall,
  input wire logic [3:0] i_busy_cycles,
  input wire logic i_absent,
  input wire logic i_mem_request_n,
  input wire logic i_lock,
  input wire logic i_coproc_instr_n,
  output logic o_stretch_request_n,
  output logic o_coproc_absent,
  output logic o_coproc_busy,
  output logic o_other_grant
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] stall_q;
  logic [3:0] busy_q;

  // Other masters shut out while locked
  assign o_other_grant = ~i_lock;

  // Stall count armed by the announce cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      stall_q <= 4'h0;
      o_stretch_request_n <= 1'b1;
    end else if (!i_mem_request_n) begin
      stall_q <= i_stall;
      o_stretch_request_n <= (i_stall == 4'h0);
    end else if (stall_q != 4'h0) begin
      stall_q <= stall_q - 4'h1;
      o_stretch_request_n <= (stall_q == 4'h1);
    end
  end

  // Busy primed while idle, so the first probe edge already sees it
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      busy_q <= 4'h0;
      o_coproc_busy <= 1'b0;
      o_coproc_absent <= 1'b0;
    end else begin
      o_coproc_absent <= i_absent;
      if (i_coproc_instr_n) begin
        busy_q <= i_busy_cycles;
        o_coproc_busy <= (i_busy_cycles != 4'h0);
      end else if (busy_q != 4'h0) begin
        busy_q <= busy_q - 4'h1;
        o_coproc_busy <= (busy_q > 4'h1);
      end
    end
  end
endmodule

//--- tb/testbench.sv
/*
  Self-checking bench for the pin block with the far side model.
  Assumes the package constants and the hand-over timing.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_acc_valid = 1'b0;
  cpi_pkg::cpi_access_t i_acc = '0;
  logic [31:0] i_wdata = 32'h0;
  logic i_write_drive_enable_n = 1'b1;
  logic i_cp_req = 1'b0;
  logic i_cp_comms_xfer = 1'b0;
  cpi_pkg::cpi_int_pins_t i_int_pins = 2'h3;
  logic i_interrupt_sync_select = 1'b1;
  logic i_fast_int_enable = 1'b0;
  logic i_normal_int_enable = 1'b0;
  logic [4:0] i_mode_bits = 5'h0;
  logic i_instr_skipped = 1'b0;
  logic i_tck = 1'b0;
  logic i_tap_update_ir = 1'b0;
  logic [3:0] i_tap_ir_next = 4'h0;
  logic [3:0] stall = 4'h0;
  logic [3:0] busy_cfg = 4'h0;
  logic absent_cfg = 1'b0;
  logic stretch_n, cp_absent, cp_busy, acc_ready, acc_done, cp_done, cp_undef;
  logic mreq_n, fetch_n, lock, wflag_n, oe, cpi_n, comms_n, ft_o, nt_o, float_n, skip_o;
  logic [1:0] size_o;
  logic [31:0] wdata_o;
  logic [4:0] mode_o;
  logic [3:0] ir_o;
  logic [3:0] ir_exp;
  logic grant;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [37:0] acc_q[$];
  logic [1:0] cp_q[$];
  logic [37:0] cur;
  logic [37:0] got;
  logic in_acc = 1'b0;
  logic prev_req_n = 1'b1;

  cpi_pin_if cpi_pin_if_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_acc_valid(i_acc_valid),
    .i_acc(i_acc), .i_wdata(i_wdata), .o_acc_ready(acc_ready), .o_acc_done(acc_done),
    .i_stretch_request_n(stretch_n), .i_write_drive_enable_n(i_write_drive_enable_n),
    .o_mem_request_n(mreq_n), .o_access_size(size_o), .o_fetch_flag_n(fetch_n),
    .o_lock(lock), .o_write_cycle_flag_n(wflag_n), .o_wdata(wdata_o), .o_wdata_oe(oe),
    .i_cp_req(i_cp_req), .i_cp_comms_xfer(i_cp_comms_xfer), .o_cp_done(cp_done),
    .o_cp_undef(cp_undef), .i_coproc_absent(cp_absent), .i_coproc_busy(cp_busy),
    .o_coproc_instr_n(cpi_n), .o_comms_transfer_flag_n(comms_n), .i_int_pins(i_int_pins),
    .i_interrupt_sync_select(i_interrupt_sync_select), .i_fast_int_enable(i_fast_int_enable),
    .i_normal_int_enable(i_normal_int_enable), .o_fast_int_take(ft_o),
    .o_normal_int_take(nt_o), .i_mode_bits(i_mode_bits), .i_instr_skipped(i_instr_skipped),
    .o_mode_bits_inv(mode_o), .o_skipped_instr_flag(skip_o), .i_tck(i_tck),
    .i_tap_update_ir(i_tap_update_ir), .i_tap_ir_next(i_tap_ir_next),
    .o_tap_instruction_out(ir_o), .o_float_select_n(float_n));

  cpi_far_side_model cpi_far_side_model_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_stall(stall), .i_busy_cycles(busy_cfg), .i_absent(absent_cfg),
    .i_mem_request_n(mreq_n), .i_lock(lock), .i_coproc_instr_n(cpi_n),
    .o_stretch_request_n(stretch_n), .o_coproc_absent(cp_absent),
    .o_coproc_busy(cp_busy), .o_other_grant(grant));

  always #20 i_clk = ~i_clk;

  task automatic chk_acc(input logic [37:0] g, input logic [37:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic test_done();
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Access monitor: flags appear the cycle after the announce pulse
  always @(negedge i_clk) begin
    if (!i_sys_rst) begin
      if (in_acc && acc_done === 1'b1) begin
        chk_val({lock, wflag_n, fetch_n, acc_ready}, 4'h7);
        in_acc = 1'b0;
      end else if (in_acc) begin
        got = {size_o, fetch_n, lock, wflag_n, oe, cur[33] ? cur[31:0] : wdata_o};
        chk_acc(got, cur);
      end
      if (prev_req_n === 1'b0) begin
        if (acc_q.size() == 0) chk_val(32'h1, 32'h0);
        else begin
          cur = acc_q.pop_front();
          in_acc = 1'b1;
          got = {size_o, fetch_n, lock, wflag_n, oe, cur[33] ? cur[31:0] : wdata_o};
          chk_acc(got, cur);
          chk_val({acc_ready, grant}, {1'b0, ~cur[34]});
        end
      end
      if (!in_acc) chk_val(lock, 1'b0);
      if (cp_done === 1'b1 || cp_undef === 1'b1) begin
        if (cp_q.size() == 0) chk_val(32'h1, 32'h0);
        else chk_val({cp_done, cp_undef}, cp_q.pop_front());
      end
      prev_req_n = mreq_n;
    end
  end

  task automatic do_acc(input logic [1:0] sz, input logic wr, fe, sw, input logic [3:0] st);
    logic [31:0] wd;
    logic en_n;
    int n;
    wd = $urandom();
    en_n = 1'($urandom());
    @(posedge i_clk);
    i_acc_valid <= 1'b1;
    i_acc <= '{size: sz, write: wr, fetch: fe, swap: sw};
    i_wdata <= wd;
    i_write_drive_enable_n <= en_n;
    stall <= st;
    acc_q.push_back({(sz == 2'h3) ? cpi_pkg::SIZE_WORD : sz, ~fe, sw, ~wr, wr & ~en_n, wd});
    @(posedge i_clk);
    // Valid held into the announce cycle, must be refused
    @(posedge i_clk);
    i_acc_valid <= 1'b0;
    n = 2;
    while (n < 40) begin
      @(negedge i_clk);
      if (acc_done === 1'b1) break;
      @(posedge i_clk);
      n++;
    end
    chk_val(n, 3 + st);
  endtask

  task automatic do_cp(input logic ab, input logic [3:0] bc, input logic cm);
    int n;
    absent_cfg <= ab;
    busy_cfg <= bc;
    repeat (2) @(posedge i_clk);
    i_cp_req <= 1'b1;
    i_cp_comms_xfer <= cm;
    cp_q.push_back({~ab, ab});
    @(posedge i_clk);
    i_cp_req <= 1'b0;
    n = 1;
    @(negedge i_clk);
    chk_val({cpi_n, comms_n}, {1'b0, ~cm});
    while (n < 40) begin
      @(posedge i_clk);
      n++;
      @(negedge i_clk);
      if (cp_done === 1'b1 || cp_undef === 1'b1) break;
    end
    chk_val(n, ab ? 2 : 2 + bc);
  endtask

  task automatic do_int(input logic ss);
    logic [1:0] pins;
    logic fe, ne, ft, nt;
    pins = 2'($urandom());
    fe = 1'($urandom());
    ne = 1'($urandom());
    ft = ~pins[1] & fe;
    nt = ~pins[0] & ne & ~ft;
    @(posedge i_clk);
    i_int_pins <= pins;
    i_interrupt_sync_select <= ss;
    i_fast_int_enable <= fe;
    i_normal_int_enable <= ne;
    @(posedge i_clk);
    @(negedge i_clk);
    if (ss) chk_val({ft_o, nt_o}, {ft, nt});
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk_val({ft_o, nt_o}, {ft, nt});
  endtask

  task automatic do_tap(input logic [3:0] ir, input logic up);
    @(posedge i_clk);
    i_tck <= 1'b1;
    i_tap_update_ir <= up;
    i_tap_ir_next <= ir;
    @(posedge i_clk);
    i_tck <= 1'b0;
    @(negedge i_clk);
    chk_val(ir_o, ir_exp);
    repeat (2) @(posedge i_clk);
    if (up) ir_exp = ir;
    @(negedge i_clk);
    chk_val({ir_o, float_n}, {ir_exp, ir_exp !== cpi_pkg::FLOAT_INSTRUCTION});
  endtask

  // Ceiling well above the fewer than two hundred cycles the run needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    logic [4:0] m;
    logic sk;
    void'($urandom(32'h12d7));
    ir_exp = cpi_pkg::TAP_IR_RESET;
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    chk_val({mreq_n, size_o, lock, ir_o, mode_o, float_n},
      {1'b1, cpi_pkg::SIZE_RESET, 1'b0, cpi_pkg::TAP_IR_RESET, cpi_pkg::MODE_INV_RESET,
      1'b1});
    for (int k = 0; k < 8; k++) begin
      do_acc(2'(k), k[2], ~k[2] & k[0], 1'b0, 4'($urandom_range(3, 0)));
    end
    do_acc(cpi_pkg::SIZE_WORD, 1'b0, 1'b0, 1'b1, 4'h2);
    do_acc(cpi_pkg::SIZE_BYTE, 1'b1, 1'b0, 1'b1, 4'h6);
    do_cp(1'b1, 4'h0, 1'b0);
    do_cp(1'b0, 4'h0, 1'b1);
    do_cp(1'b0, 4'h3, 1'b0);
    do_cp(1'b1, 4'h2, 1'b1);
    for (int k = 0; k < 12; k++) do_int(k[0]);
    repeat (6) begin
      m = 5'($urandom());
      sk = 1'($urandom());
      @(posedge i_clk);
      i_mode_bits <= m;
      i_instr_skipped <= sk;
      @(posedge i_clk);
      @(negedge i_clk);
      chk_val({mode_o, skip_o}, {~m, sk});
    end
    do_tap(4'h3, 1'b1);
    do_tap(cpi_pkg::FLOAT_INSTRUCTION, 1'b1);
    do_tap(4'h5, 1'b0);
    do_tap(4'hA, 1'b1);
    repeat (4) @(posedge i_clk);
    test_done();
  end
endmodule
